// file: fbsm_map.vh
// register map, field layout, state and error codes of the application layer state block
`ifndef FBSM_MAP_VH
`define FBSM_MAP_VH
`define FBSM_ADDR_W 12
`define FBSM_OFS_REQ 12'h120
`define FBSM_OFS_REPORT 12'h130
`define FBSM_OFS_ERRCODE 12'h134
`define FBSM_OFS_IRQ_STAT 12'h140
`define FBSM_OFS_IRQ_MASK 12'h144
`define FBSM_OFS_CFG 12'h148
`define FBSM_ST_INIT 4'h1
`define FBSM_ST_PREOP 4'h2
`define FBSM_ST_BOOT 4'h3
`define FBSM_ST_SAFEOP 4'h4
`define FBSM_ST_OP 4'h8
`define FBSM_REQ_STATE_MSB 3
`define FBSM_REQ_ACK_BIT 4
`define FBSM_REQ_RW_MASK 16'h001f
`define FBSM_EC_NONE 16'h0000
`define FBSM_EC_UNSPEC 16'h0001
`define FBSM_EC_BADCHG 16'h0011
`define FBSM_EC_UNKNOWN 16'h0012
`define FBSM_EC_MBX_BOOT 16'h0015
`define FBSM_EC_MBX_PREOP 16'h0016
`define FBSM_EC_BUFCFG 16'h0017
`define FBSM_EC_WDOG 16'h001b
`define FBSM_EC_OUTCFG 16'h001d
`define FBSM_EC_INCFG 16'h001e
`define FBSM_IRQ_W 3
`define FBSM_IRQ_CHANGE 0
`define FBSM_IRQ_REFUSE 1
`define FBSM_IRQ_FAULT 2
`define FBSM_CFG_MBX_OK 0
`define FBSM_CFG_BUF_OK 1
`define FBSM_CFG_RST 16'h0003
`endif

// file: fbsm_master.sv
// network master model issuing register writes and reads
module fbsm_master (
    input wire logic mclk_i,
    input wire logic [15:0] rdata_i,
    output logic [11:0] addr_o,
    output logic [15:0] wdata_o,
    output logic wr_o,
    output logic rd_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // bus idle at time zero
    initial begin
        addr_o = 12'h000;
        wdata_o = 16'h0000;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    // one-cycle write; request register writes get bits 7:5 cleared, bits 15:8 pass
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        addr_o <= a;
        wdata_o <= (a == 12'h120) ? (d & 16'hff1f) : d;
        wr_o <= 1'b1;
        @(posedge mclk_i);
        wr_o <= 1'b0;
        wdata_o <= ~d; // released bus shows no stale value
    endtask
    // one-cycle read; data taken at the edge closing the following cycle
    task automatic rd(input logic [11:0] a, output logic [15:0] d);
        @(posedge mclk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge mclk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        @(posedge mclk_i);
        d = rdata_i;
    endtask
endmodule // fbsm_master

// file: fbsm_props.sv
// port assertions for the state block
module fbsm_props (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [11:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [15:0] rdata_o,
    input wire logic wdog_expired_i,
    input wire logic out_cfg_bad_i,
    input wire logic in_cfg_bad_i,
    input wire logic unspec_err_i,
    input wire logic [3:0] state_o,
    input wire logic irq_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);
    // request decode and single-fault windows; overlapping faults resolve in a fixed priority: watchdog, output, input, unspecified
    wire req_w = wr_i && addr_i == 12'h120;
    wire [3:0] rq = wdata_i[3:0];
    wire wd_only = wdog_expired_i && !in_cfg_bad_i && !wr_i;
    wire in_only = in_cfg_bad_i && !wdog_expired_i && !out_cfg_bad_i && !wr_i;
    a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
        else $error("read data not idle");
    a_state_legal: assert property (state_o inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h8})
        else $error("illegal state");
    a_report_read: assert property (rd_i && addr_i == 12'h130
        |=> rdata_o[3:0] == $past(state_o) && rdata_o[15:5] == 11'h000) else $error("report mismatch");
    a_unknown_kept: assert property (req_w && !(rq inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h8})
        && state_o inside {4'h1, 4'h2, 4'h3} |=> $stable(state_o)) else $error("unknown request moved");
    a_init_refuse: assert property (req_w && state_o == 4'h1 && rq inside {4'h4, 4'h8}
        |=> state_o == 4'h1) else $error("init left illegally");
    a_preop_refuse: assert property (req_w && state_o == 4'h2 && rq inside {4'h3, 4'h8}
        |=> state_o == 4'h2) else $error("preop left illegally");
    a_boot_exit: assert property (req_w && state_o == 4'h3 && rq inside {4'h2, 4'h4, 4'h8}
        |=> state_o == 4'h3) else $error("boot left illegally");
    a_wdog_force: assert property (wd_only && state_o == 4'h8 ##1 wd_only[*3] |=> state_o == 4'h4)
        else $error("watchdog not forcing safeop");
    a_infault_force: assert property (in_only && state_o == 4'h4 ##1 in_only[*3] |=> state_o == 4'h2)
        else $error("input fault not forcing preop");
    c_refuse: cover property (req_w && state_o == 4'h2 && rq == 4'h8);
    c_irq: cover property ($rose(irq_o));
    c_fault: cover property (state_o == 4'h4 ##1 state_o == 4'h2);
endmodule // fbsm_props
bind fbsm_state_ctrl fbsm_props i_props (.mclk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .wdog_expired_i, .out_cfg_bad_i, .in_cfg_bad_i, .unspec_err_i, .state_o, .irq_o);

// file: fbsm_state_ctrl.v
// application layer slave state machine with register port and interrupt
`include "fbsm_map.vh"
module fbsm_state_ctrl (
    input wire mclk_i,
    input wire rst_i,
    input wire [`FBSM_ADDR_W-1:0] addr_i,
    input wire [15:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [15:0] rdata_o,
    input wire wdog_expired_i,
    input wire out_cfg_bad_i,
    input wire in_cfg_bad_i,
    input wire unspec_err_i,
    output reg [3:0] state_o,
    output reg irq_o
);
    // register state
    reg [3:0] state_q;
    reg [3:0] state_d;
    reg flag_q;
    reg flag_d;
    reg [15:0] req_q;
    reg [15:0] code_q;
    reg [15:0] code_d;
    reg [15:0] cfg_q;
    reg [`FBSM_IRQ_W-1:0] irq_stat_q;
    reg [`FBSM_IRQ_W-1:0] irq_mask_q;
    reg [`FBSM_IRQ_W-1:0] irq_ev;
    reg [15:0] rdata_d;
    wire [3:0] chk_next;
    wire [15:0] chk_code;
    wire chk_refuse;
    wire [3:0] fault_sync;
    wire wdog_s;
    wire outcfg_s;
    wire incfg_s;
    wire unspec_s;
    wire req_wr;
    wire ack_wr;
    wire stat_wr;
    wire mask_wr;
    wire cfg_wr;
    reg fault_hit;

    // fault lines come from outside this clock, so they are synchronised first
    fbsm_sync2 #(
        .W(4)
    ) u_sync (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .d_i({unspec_err_i, in_cfg_bad_i, out_cfg_bad_i, wdog_expired_i}),
        .q_o(fault_sync)
    );
    assign wdog_s = fault_sync[0];
    assign outcfg_s = fault_sync[1];
    assign incfg_s = fault_sync[2];
    assign unspec_s = fault_sync[3];

    // address decode of write strobes
    assign req_wr = wr_i && (addr_i == `FBSM_OFS_REQ);
    assign ack_wr = req_wr && wdata_i[`FBSM_REQ_ACK_BIT];
    assign stat_wr = wr_i && (addr_i == `FBSM_OFS_IRQ_STAT);
    assign mask_wr = wr_i && (addr_i == `FBSM_OFS_IRQ_MASK);
    assign cfg_wr = wr_i && (addr_i == `FBSM_OFS_CFG);

    // verdict of the requested transition, using the written value directly
    fbsm_transition_check u_check (
        .cur_i(state_q),
        .req_i(wdata_i[`FBSM_REQ_STATE_MSB:0]),
        .mbx_ok_i(cfg_q[`FBSM_CFG_MBX_OK]),
        .buf_ok_i(cfg_q[`FBSM_CFG_BUF_OK]),
        .next_o(chk_next),
        .code_o(chk_code),
        .refuse_o(chk_refuse)
    );

    // next state, flag and error code; runtime faults outrank a request in the same cycle
    always @* begin
        state_d = state_q;
        flag_d = flag_q;
        code_d = code_q;
        fault_hit = 1'b0;
        irq_ev = {`FBSM_IRQ_W{1'b0}};
        // acknowledge first so a refusal or fault in this cycle sets the flag again
        if (ack_wr) begin
            flag_d = 1'b0;
        end
        if (req_wr) begin
            if (chk_refuse) begin
                flag_d = 1'b1;
                code_d = chk_code;
                irq_ev[`FBSM_IRQ_REFUSE] = 1'b1;
            end else begin
                state_d = chk_next;
                code_d = `FBSM_EC_NONE;
                if (chk_next != state_q) begin
                    irq_ev[`FBSM_IRQ_CHANGE] = 1'b1;
                end
            end
        end
        if ((wdog_s || outcfg_s) && (state_q == `FBSM_ST_OP || state_q == `FBSM_ST_SAFEOP)) begin
            state_d = `FBSM_ST_SAFEOP;
            code_d = wdog_s ? `FBSM_EC_WDOG : `FBSM_EC_OUTCFG;
            fault_hit = 1'b1;
        end else if (incfg_s && (state_q == `FBSM_ST_OP || state_q == `FBSM_ST_SAFEOP)) begin
            state_d = `FBSM_ST_PREOP;
            code_d = `FBSM_EC_INCFG;
            fault_hit = 1'b1;
        end else if (unspec_s && !flag_q) begin
            // unspecified error keeps the state; reported once until acknowledged
            code_d = `FBSM_EC_UNSPEC;
            fault_hit = 1'b1;
        end
        if (fault_hit) begin
            flag_d = 1'b1;
            irq_ev[`FBSM_IRQ_FAULT] = 1'b1;
        end
    end

    // register file and state machine flops
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= `FBSM_ST_INIT;
            flag_q <= 1'b0;
            req_q <= {12'h000, `FBSM_ST_INIT};
            code_q <= `FBSM_EC_NONE;
            cfg_q <= `FBSM_CFG_RST;
            irq_mask_q <= {`FBSM_IRQ_W{1'b0}};
        end else begin
            state_q <= state_d;
            flag_q <= flag_d;
            code_q <= code_d;
            if (req_wr) begin
                req_q <= wdata_i & `FBSM_REQ_RW_MASK;
            end
            if (cfg_wr) begin
                cfg_q <= wdata_i;
            end
            if (mask_wr) begin
                irq_mask_q <= wdata_i[`FBSM_IRQ_W-1:0];
            end
        end
    end

    // sticky interrupt bits per event; a new event wins over a write-one clear
    genvar gi;
    generate
        for (gi = 0; gi < `FBSM_IRQ_W; gi = gi + 1) begin : g_irq
            always @(posedge mclk_i or posedge rst_i) begin
                if (rst_i) begin
                    irq_stat_q[gi] <= 1'b0;
                end else if (irq_ev[gi]) begin
                    irq_stat_q[gi] <= 1'b1;
                end else if (stat_wr && wdata_i[gi]) begin
                    irq_stat_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // read mux; unmapped addresses read zero
    always @* begin
        rdata_d = 16'h0000;
        if (rd_i) begin
            case (addr_i)
                `FBSM_OFS_REQ: rdata_d = req_q;
                `FBSM_OFS_REPORT: rdata_d = {11'h000, flag_q, state_q};
                `FBSM_OFS_ERRCODE: rdata_d = code_q;
                `FBSM_OFS_IRQ_STAT: rdata_d = {13'h0000, irq_stat_q};
                `FBSM_OFS_IRQ_MASK: rdata_d = {13'h0000, irq_mask_q};
                `FBSM_OFS_CFG: rdata_d = cfg_q;
                default: rdata_d = 16'h0000;
            endcase
        end
    end

    // outputs straight from flops; irq follows status one cycle later
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 16'h0000;
            state_o <= `FBSM_ST_INIT;
            irq_o <= 1'b0;
        end else begin
            rdata_o <= rdata_d;
            state_o <= state_d;
            irq_o <= |(irq_stat_q & irq_mask_q);
        end
    end
endmodule // fbsm_state_ctrl

// file: fbsm_sync2.v
// two flip-flop synchroniser for a group of level inputs
module fbsm_sync2 #(
    parameter W = 3
) (
    input wire mclk_i,
    input wire rst_i,
    input wire [W-1:0] d_i,
    output wire [W-1:0] q_o
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    // first stage feeds only the second
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end else begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;
endmodule // fbsm_sync2

// file: fbsm_transition_check.v
// decides the outcome of a requested state transition
`include "fbsm_map.vh"
module fbsm_transition_check (
    input wire [3:0] cur_i,
    input wire [3:0] req_i,
    input wire mbx_ok_i,
    input wire buf_ok_i,
    output reg [3:0] next_o,
    output reg [15:0] code_o,
    output reg refuse_o
);
    // pure combinational verdict so the main block's next-state logic needs no transition table of its own
    always @* begin
        next_o = cur_i;
        code_o = `FBSM_EC_NONE;
        refuse_o = 1'b0;
        if (req_i != `FBSM_ST_INIT && req_i != `FBSM_ST_PREOP && req_i != `FBSM_ST_BOOT &&
            req_i != `FBSM_ST_SAFEOP && req_i != `FBSM_ST_OP) begin
            code_o = `FBSM_EC_UNKNOWN;
            refuse_o = 1'b1;
        end else if ((cur_i == `FBSM_ST_INIT && (req_i == `FBSM_ST_SAFEOP || req_i == `FBSM_ST_OP)) ||
                     (cur_i == `FBSM_ST_PREOP && req_i == `FBSM_ST_OP) ||
                     (cur_i != `FBSM_ST_INIT && cur_i != `FBSM_ST_BOOT && req_i == `FBSM_ST_BOOT)) begin
            code_o = `FBSM_EC_BADCHG;
            refuse_o = 1'b1;
        end else if (cur_i == `FBSM_ST_BOOT && req_i != `FBSM_ST_INIT && req_i != `FBSM_ST_BOOT) begin
            // bootstrap may only fall back to init
            code_o = `FBSM_EC_BADCHG;
            refuse_o = 1'b1;
        end else if (cur_i == `FBSM_ST_INIT && req_i == `FBSM_ST_BOOT && !mbx_ok_i) begin
            code_o = `FBSM_EC_MBX_BOOT;
            refuse_o = 1'b1;
        end else if (cur_i == `FBSM_ST_INIT && req_i == `FBSM_ST_PREOP && !mbx_ok_i) begin
            code_o = `FBSM_EC_MBX_PREOP;
            refuse_o = 1'b1;
        end else if (((cur_i == `FBSM_ST_PREOP && req_i == `FBSM_ST_SAFEOP) ||
                      (cur_i == `FBSM_ST_SAFEOP && req_i == `FBSM_ST_OP)) && !buf_ok_i) begin
            code_o = `FBSM_EC_BUFCFG;
            refuse_o = 1'b1;
        end else begin
            next_o = req_i;
        end
    end
endmodule // fbsm_transition_check

// file: tb_top.sv
// self-checking bench for the state block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] flt = 4'h0;
    logic [11:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic wr;
    logic rd;
    logic irq;
    logic [3:0] st;
    int num_errors = 0;
    int checked = 0;
    // entries {cfg, request, expected state, expected code}
    logic [27:0] tbl [0:21] = '{28'h2310015, 28'h2210016, 28'h3410011, 28'h3810011, 28'h3f10012,
        28'h3220000, 28'h3820011, 28'h3320011, 28'h3020012, 28'h1420017, 28'h3440000, 28'h3340011,
        28'h1840017, 28'h3880000, 28'h3380011, 28'h3110000, 28'h3330000, 28'h3230011, 28'h3110000,
        28'h3220000, 28'h3440000, 28'h3880000};
    initial begin
        forever #5 mclk_i = ~mclk_i;
    end
    fbsm_master i_mst (.mclk_i, .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
    fbsm_state_ctrl i_dut (.mclk_i, .rst_i, .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .wdog_expired_i(flt[0]), .out_cfg_bad_i(flt[1]), .in_cfg_bad_i(flt[2]),
        .unspec_err_i(flt[3]), .state_o(st), .irq_o(irq));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [11:0] a, input logic [15:0] exp);
        logic [15:0] v;
        i_mst.rd(a, v);
        chk(v, exp);
    endtask
    // request a state, check report, code and port, then acknowledge a raised flag
    task automatic step(input logic [3:0] req, input logic [3:0] se, input logic [15:0] code);
        i_mst.wr(12'h120, {12'h000, req});
        rchk(12'h130, {11'h000, code != 16'h0000, se});
        rchk(12'h134, code);
        chk({12'h000, st}, {12'h000, se});
        if (code != 16'h0000) i_mst.wr(12'h120, {11'h000, 1'b1, se});
    endtask
    // hold a fault past the two-stage synchroniser, then check and acknowledge
    task automatic fault(input logic [3:0] f, input logic [15:0] rep, input logic [15:0] code);
        @(posedge mclk_i);
        flt <= f;
        repeat (4) @(posedge mclk_i);
        flt <= 4'h0;
        repeat (3) @(posedge mclk_i);
        rchk(12'h130, rep);
        rchk(12'h134, code);
        i_mst.wr(12'h120, {11'h000, 1'b1, rep[3:0]});
    endtask
    task automatic finish_test();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // reset, then register, interrupt, transition and fault sequences
    initial begin
        repeat (12) @(posedge mclk_i);
        rst_i <= 1'b0;
        rchk(12'h130, 16'h0001);
        rchk(12'h134, 16'h0000);
        rchk(12'h120, 16'h0001);
        rchk(12'h200, 16'h0000);
        i_mst.wr(12'h144, 16'h0007);
        step(4'h8, 4'h1, 16'h0011);
        chk({15'h0000, irq}, 16'h0001);
        rchk(12'h140, 16'h0002);
        i_mst.wr(12'h140, 16'h0007);
        repeat (2) @(posedge mclk_i);
        chk({15'h0000, irq}, 16'h0000);
        i_mst.wr(12'h144, 16'h0000);
        step(4'h5, 4'h1, 16'h0012);
        chk({15'h0000, irq}, 16'h0000);
        // a request without the acknowledge bit leaves the raised flag alone
        i_mst.wr(12'h120, 16'h0004);
        rchk(12'h130, 16'h0011);
        i_mst.wr(12'h120, 16'h0001);
        rchk(12'h130, 16'h0011);
        rchk(12'h134, 16'h0000);
        i_mst.wr(12'h120, 16'h0011);
        rchk(12'h130, 16'h0001);
        i_mst.wr(12'h134, 16'hffff);
        rchk(12'h134, 16'h0000);
        foreach (tbl[i]) begin
            i_mst.wr(12'h148, {12'h000, tbl[i][27:24]});
            step(tbl[i][23:20], tbl[i][19:16], tbl[i][15:0]);
        end
        fault(4'h1, 16'h0014, 16'h001b);
        fault(4'h2, 16'h0014, 16'h001d);
        fault(4'h4, 16'h0012, 16'h001e);
        fault(4'h8, 16'h0012, 16'h0001);
        rchk(12'h130, 16'h0002);
        finish_test();
    end
endmodule // tb_top
